// ### rtl/irqcnr_defines.svh
// Register offsets, field positions and reset values of the clear/NMI/reset-cause bank
`ifndef IRQCNR_DEFINES_SVH
`define IRQCNR_DEFINES_SVH

// Register byte offsets
`define IRQCNR_OFS_IRQ_CLEAR      12'h000
`define IRQCNR_OFS_NMI_FLAGS      12'h004
`define IRQCNR_OFS_RESET_CAUSE    12'h008

// Clear code field
`define IRQCNR_CLR_CODE_W         5
`define IRQCNR_CLR_VALID_MAX      5'h07

// NMI flag positions
`define IRQCNR_NMI_WDT_BIT        0
`define IRQCNR_NMI_PIN_BIT        1
`define IRQCNR_NMI_BELOW_BIT      2
`define IRQCNR_NMI_ABOVE_BIT      3
`define IRQCNR_NMI_W              4

// Reset-cause positions
`define IRQCNR_RST_PON_BIT        0
`define IRQCNR_RST_PIN_BIT        1
`define IRQCNR_RST_WDT_BIT        2
`define IRQCNR_RST_STOP_BIT       3
`define IRQCNR_RST_DBG_BIT        4
`define IRQCNR_RST_OFD_BIT        5
`define IRQCNR_RST_LVD_BIT        6
`define IRQCNR_RST_W              7

// Reset values
`define IRQCNR_NMI_RESET          4'h0
`define IRQCNR_RST_PON_RESET      7'h01

`endif

// ### rtl/irqcnr_pkg.sv
// Types shared by the clear/NMI/reset-cause register bank
package irqcnr_pkg;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } irqcnr_apb_req_s;

  typedef struct packed {
    logic fromWatchdog;
    logic fromPin;
    logic voltageBelow;
    logic voltageAbove;
  } irqcnr_nmi_src_s;

  typedef struct packed {
    logic lowVoltage;
    logic oscFail;
    logic debugRequest;
    logic deepStopRelease;
    logic watchdog;
    logic pin;
  } irqcnr_rst_src_s;

endpackage : irqcnr_pkg

// ### rtl/irqcnr_bank.sv
// APB register bank: standby-clear request clear, NMI source flags, reset-cause flags
//
// Functional notes
// - Write of code 0..7 clears that external interrupt's standby request; field reads zero
// - NMI flag bit 0 set by a watchdog NMI
// - NMI flag bit 1 set by the NMI input pin
// - NMI flag bit 2 set by voltage detector below threshold while falling
// - NMI flag bit 3 set by voltage detector above threshold while falling
// - Reading NMI flags returns them, then clears all four except any with a new event in that cycle
// - Reset-cause flags only clear when software writes zero or power-on reset is asserted
// - Power-on flag bit 0 set while power-on reset is asserted
// - Pin bit 1, watchdog bit 2, oscillation fail bit 5, low voltage bit 6
// - After power-on, flags other than power-on are invalid until cleared
// - Debug flag bit 4 set by core system reset request
// - Deep-stop release flag bit 3 set on reset leaving deep stop mode
// - Pin flag bit 1 set when the external reset pin resets the device
// - Clearing a request also clears that source's detected-edge status
`timescale 1ns/10ps
`default_nettype none
`include "irqcnr_defines.svh"

module irqcnr_bank
  import irqcnr_pkg::*;
#(
  parameter int NUM_EXT_IRQ = 8
) (
  input  wire logic                   clk,
  input  wire logic                   resetn,
  input  wire logic                   powerOnResetn,
  input  wire irqcnr_apb_req_s        apbReq,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire irqcnr_nmi_src_s        nmiEvent,
  input  wire irqcnr_rst_src_s        resetCause,
  output logic [NUM_EXT_IRQ-1:0]      standbyClearPulse,
  output logic [NUM_EXT_IRQ-1:0]      edgeStatusClearPulse,
  output logic [`IRQCNR_NMI_W-1:0]    nmiSourceFlags,
  output logic [`IRQCNR_RST_W-1:0]    resetCauseFlags
);

  // ==========================================================
  // Bus decode
  // ==========================================================
  logic                         setupPhase;
  logic                         accessEnd;
  logic                         writeAccess;
  logic                         readAccess;
  logic                         hitClear;
  logic                         hitNmi;
  logic                         hitCause;
  logic [`IRQCNR_NMI_W-1:0]     next_nmi;
  logic [`IRQCNR_RST_W-1:0]     next_cause;

  function automatic logic addrHit(input logic [11:0] addr, input logic [11:0] ofs);
    addrHit = (addr == ofs);
  endfunction : addrHit

  assign setupPhase  = apbReq.psel && !apbReq.penable;
  // No wait state: pready is registered from the setup phase
  assign accessEnd   = apbReq.psel && apbReq.penable && pready;
  assign writeAccess = accessEnd && apbReq.pwrite;
  assign readAccess  = accessEnd && !apbReq.pwrite;
  assign hitClear    = addrHit(apbReq.paddr, `IRQCNR_OFS_IRQ_CLEAR);
  assign hitNmi      = addrHit(apbReq.paddr, `IRQCNR_OFS_NMI_FLAGS);
  assign hitCause    = addrHit(apbReq.paddr, `IRQCNR_OFS_RESET_CAUSE);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setupPhase;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setupPhase && !(hitClear || hitNmi || hitCause);
    end
  end

  // ==========================================================
  // Read data, captured at setup from the next flag values
  // ==========================================================
  // An event sampled at the setup edge must reach the snapshot, or the
  // read-clear one cycle later would lose it unseen.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h00000000;
    end else if (setupPhase && !apbReq.pwrite) begin
      prdata <= 32'h00000000;
      if (hitNmi) begin
        prdata[`IRQCNR_NMI_W-1:0] <= next_nmi;
      end
      if (hitCause) begin
        prdata[`IRQCNR_RST_W-1:0] <= next_cause;
      end
      // Clear register is write-only and reads as zero
    end else if (!apbReq.psel) begin
      prdata <= 32'h00000000;
    end
  end

  // ==========================================================
  // Standby-clear request clear
  // ==========================================================
  logic [`IRQCNR_CLR_CODE_W-1:0] clearCode;
  assign clearCode = apbReq.pwdata[`IRQCNR_CLR_CODE_W-1:0];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      standbyClearPulse    <= '0;
      edgeStatusClearPulse <= '0;
    end else begin
      standbyClearPulse    <= '0;
      edgeStatusClearPulse <= '0;
      // Reserved codes do nothing
      if (writeAccess && hitClear && clearCode <= `IRQCNR_CLR_VALID_MAX) begin
        standbyClearPulse[clearCode[2:0]]    <= 1'b1;
        edgeStatusClearPulse[clearCode[2:0]] <= 1'b1;
      end
    end
  end

  // ==========================================================
  // NMI source flags: read to clear, event wins over the clear
  // ==========================================================
  always_comb begin
    next_nmi = nmiSourceFlags;
    if (readAccess && hitNmi) begin
      next_nmi = '0;
    end
    if (nmiEvent.fromWatchdog) next_nmi[`IRQCNR_NMI_WDT_BIT] = 1'b1;
    if (nmiEvent.fromPin) next_nmi[`IRQCNR_NMI_PIN_BIT] = 1'b1;
    if (nmiEvent.voltageBelow) next_nmi[`IRQCNR_NMI_BELOW_BIT] = 1'b1;
    if (nmiEvent.voltageAbove) next_nmi[`IRQCNR_NMI_ABOVE_BIT] = 1'b1;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      nmiSourceFlags <= `IRQCNR_NMI_RESET;
    end else begin
      nmiSourceFlags <= next_nmi;
    end
  end

  // ==========================================================
  // Reset-cause flags
  // ==========================================================
  // These survive system resets; only power-on reset initialises them.
  // Other flags start at zero here, software still treats them as invalid.
  always_comb begin
    next_cause = resetCauseFlags;
    if (writeAccess && hitCause) begin
      // Writing zero clears, writing one
      next_cause = resetCauseFlags & apbReq.pwdata[`IRQCNR_RST_W-1:0];
    end
    if (resetCause.pin) next_cause[`IRQCNR_RST_PIN_BIT] = 1'b1;
    if (resetCause.watchdog) next_cause[`IRQCNR_RST_WDT_BIT] = 1'b1;
    if (resetCause.deepStopRelease) next_cause[`IRQCNR_RST_STOP_BIT] = 1'b1;
    if (resetCause.debugRequest) next_cause[`IRQCNR_RST_DBG_BIT] = 1'b1;
    if (resetCause.oscFail) next_cause[`IRQCNR_RST_OFD_BIT] = 1'b1;
    if (resetCause.lowVoltage) next_cause[`IRQCNR_RST_LVD_BIT] = 1'b1;
  end

  always_ff @(posedge clk or negedge powerOnResetn) begin
    if (!powerOnResetn) begin
      resetCauseFlags <= `IRQCNR_RST_PON_RESET;
    end else begin
      resetCauseFlags <= next_cause;
    end
  end

endmodule : irqcnr_bank

`default_nettype wire

// ### verif/irqcnr_bank_monitor.sv
// Concurrent checks on the clear/NMI/reset-cause bank ports
`timescale 1ns/10ps
`default_nettype none
module irqcnr_bank_monitor
  import irqcnr_pkg::*;
#(
  parameter int NUM_EXT_IRQ = 8
) (
  input wire logic                   clk,
  input wire logic                   resetn,
  input wire logic                   powerOnResetn,
  input wire irqcnr_apb_req_s        apbReq,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire irqcnr_nmi_src_s        nmiEvent,
  input wire irqcnr_rst_src_s        resetCause,
  input wire logic [NUM_EXT_IRQ-1:0] standbyClearPulse,
  input wire logic [NUM_EXT_IRQ-1:0] edgeStatusClearPulse,
  input wire logic [3:0]             nmiSourceFlags,
  input wire logic [6:0]             resetCauseFlags
);
  // ====================
  // Helpers
  logic [3:0] nmiVec;
  logic       setup;
  logic       acc;
  assign nmiVec = {nmiEvent.voltageAbove, nmiEvent.voltageBelow, nmiEvent.fromPin,
                   nmiEvent.fromWatchdog};
  assign setup  = apbReq.psel && !apbReq.penable;
  assign acc    = apbReq.psel && apbReq.penable && pready;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  chk_clr_pulse: assert property (
    acc && apbReq.pwrite && apbReq.paddr == 12'h000 |=> standbyClearPulse ==
    ($past(apbReq.pwdata[4:3]) == 2'h0 ? NUM_EXT_IRQ'(1) << $past(apbReq.pwdata[2:0]) : '0))
    else $error("clear pulse wrong");
  chk_pulse_cause: assert property (
    standbyClearPulse != '0 |-> $past(acc && apbReq.pwrite && apbReq.paddr == 12'h000))
    else $error("clear pulse without write");
  chk_edge_pair: assert property (edgeStatusClearPulse == standbyClearPulse)
    else $error("edge status clear differs");
  chk_nmi_set: assert property (
    1'h1 |=> (nmiSourceFlags & $past(nmiVec)) == $past(nmiVec))
    else $error("nmi flag not set");
  chk_nmi_rdclr: assert property (
    acc && !apbReq.pwrite && apbReq.paddr == 12'h004 |=> nmiSourceFlags == $past(nmiVec))
    else $error("nmi flags not cleared by read");
  chk_read_data: assert property (
    setup && !apbReq.pwrite |=> pready && prdata == {25'h0,
    $past(apbReq.paddr) == 12'h004 ? {3'h0, $past(nmiSourceFlags | nmiVec)} :
    $past(apbReq.paddr) == 12'h008 ? $past(resetCauseFlags | {resetCause, 1'b0}) : 7'h00})
    else $error("read data wrong");
  chk_unmapped_err: assert property (
    setup && !(apbReq.paddr inside {12'h000, 12'h004, 12'h008}) |=> pready && pslverr)
    else $error("no error on unmapped address");
  chk_cause_hold: assert property (
    !(acc && apbReq.pwrite && apbReq.paddr == 12'h008) |=>
    (resetCauseFlags & $past(resetCauseFlags)) == $past(resetCauseFlags))
    else $error("reset cause flag dropped");
  chk_cause_set: assert property (
    1'h1 |=> (resetCauseFlags[6:1] & $past(resetCause)) == $past(resetCause))
    else $error("reset cause flag not set");
  chk_pon_value: assert property (!powerOnResetn |-> resetCauseFlags == 7'h01)
    else $error("power-on value wrong");
endmodule : irqcnr_bank_monitor

bind irqcnr_bank irqcnr_bank_monitor #(.NUM_EXT_IRQ(NUM_EXT_IRQ)) i_mon (
  .clk(clk), .resetn(resetn), .powerOnResetn(powerOnResetn), .apbReq(apbReq),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .nmiEvent(nmiEvent),
  .resetCause(resetCause), .standbyClearPulse(standbyClearPulse),
  .edgeStatusClearPulse(edgeStatusClearPulse), .nmiSourceFlags(nmiSourceFlags),
  .resetCauseFlags(resetCauseFlags));
`default_nettype wire

// ### verif/irqcnr_bank_tb.sv
// Self-checking bench for the clear/NMI/reset-cause bank
`timescale 1ns/10ps
`default_nettype none
module irqcnr_bank_tb
  import irqcnr_pkg::*;
();
  logic clk, resetn, powerOnResetn, pready, pslverr, er;
  irqcnr_apb_req_s req;
  irqcnr_nmi_src_s nmi;
  irqcnr_rst_src_s cause;
  logic [31:0] prdata, rd, v;
  logic [7:0]  sbPulse, edPulse;
  logic [3:0]  nmiFlags;
  logic [6:0]  causeFlags, model;
  int          bad_count, checked;

  irqcnr_bank #(.NUM_EXT_IRQ(8)) i_dut (.clk(clk), .resetn(resetn),
    .powerOnResetn(powerOnResetn), .apbReq(req), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .nmiEvent(nmi), .resetCause(cause), .standbyClearPulse(sbPulse),
    .edgeStatusClearPulse(edPulse), .nmiSourceFlags(nmiFlags), .resetCauseFlags(causeFlags));

  // ====================
  // Tasks and expectations
  function automatic logic [7:0] pulse_exp(input logic [4:0] c);
    return (c < 5'h08) ? 8'h01 << c[2:0] : 8'h00;
  endfunction : pulse_exp
  function automatic logic [3:0] nmi_exp(input logic [3:0] e);
    return {e[0], e[1], e[2], e[3]};
  endfunction : nmi_exp
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
      bad_count++;
    end
  endtask : chk
  task automatic wrap_up();
    $display("Comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge clk);
    req <= '{psel: 1'h1, penable: 1'h0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    if (pready !== 1'h1) begin
      bad_count++;
      wrap_up();
    end
    r = prdata;
    e = pslverr;
    req.psel <= 1'h0;
    req.penable <= 1'h0;
  endtask : apb
  // Power-on release trails system release so its held value can be watched
  task automatic do_reset();
    resetn <= 1'h0;
    powerOnResetn <= 1'h0;
    repeat (12) @(posedge clk);
    resetn <= 1'h1;
    repeat (2) @(posedge clk);
    powerOnResetn <= 1'h1;
  endtask : do_reset

  // ====================
  // Stimulus
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    wrap_up();
  end
  initial begin
    req = '0;
    nmi = '0;
    cause = '0;
    v = $urandom(32'h6323);
    do_reset();
    for (int p = 0; p < 2; p++) begin
      apb(1'h0, 12'h008, 32'h0, rd, er); chk("cause", rd, 32'h1);
      apb(1'h0, 12'h004, 32'h0, rd, er); chk("nmi", rd, 32'h0);
      apb(1'h0, 12'h000, 32'h0, rd, er); chk("clrrd", rd, 32'h0);
      for (int c = 0; c < 32; c++) begin
        apb(1'h1, 12'h000, c, rd, er);
        @(posedge clk);
        chk("sbclr", {24'h0, sbPulse}, {24'h0, pulse_exp(c[4:0])});
        chk("edclr", {24'h0, edPulse}, {24'h0, pulse_exp(c[4:0])});
      end
      apb(1'h1, 12'h008, 32'h0, rd, er);
      model = 7'h00;
      for (int k = 0; k < 8; k++) begin
        v = $urandom;
        @(posedge clk);
        nmi <= irqcnr_nmi_src_s'(v[3:0]);
        cause <= irqcnr_rst_src_s'(v[9:4]);
        @(posedge clk);
        nmi <= '0;
        cause <= '0;
        model = model | {v[9:4], 1'h0};
        apb(1'h1, 12'h004, 32'hFFFFFFFF, rd, er);
        apb(1'h0, 12'h004, 32'h0, rd, er); chk("nmi", rd, {28'h0, nmi_exp(v[3:0])});
        apb(1'h0, 12'h004, 32'h0, rd, er); chk("nmiclr", rd, 32'h0);
        repeat (10) @(posedge clk);
        apb(1'h0, 12'h008, 32'h0, rd, er); chk("cause", rd, {25'h0, model});
        apb(1'h1, 12'h008, {25'h0, v[22:16]}, rd, er);
        model = model & v[22:16];
        apb(1'h0, 12'h008, 32'h0, rd, er); chk("causewr", rd, {25'h0, model});
      end
      apb(1'h0, 12'h00C, 32'h0, rd, er); chk("unmapped", {31'h0, er}, 32'h1);
      apb(1'h1, 12'h010, 32'hFFFFFFFF, rd, er);
      apb(1'h0, 12'h008, 32'h0, rd, er); chk("causekept", rd, {25'h0, model});
      chk("okresp", {31'h0, er}, 32'h0);
      do_reset();
    end
    wrap_up();
  end
endmodule : irqcnr_bank_tb
`default_nettype wire
